// ==== sfsp_defs.vh ====
/*
 * Constants of the serial flash status and protection block: command codes,
 * status bit positions, power-on values and operation times.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SFSP_DEFS_VH
`define SFSP_DEFS_VH

// ****************************************
// Command codes
// ****************************************
`define SFSP_CMD_WREN_LATCH 8'h06
`define SFSP_CMD_WR_DISABLE 8'h04
`define SFSP_CMD_RD_LOW 8'h05
`define SFSP_CMD_RD_MID 8'h35
`define SFSP_CMD_RD_HIGH 8'h15
`define SFSP_CMD_WR_LOW 8'h01
`define SFSP_CMD_WR_MID 8'h31
`define SFSP_CMD_WR_HIGH 8'h11
`define SFSP_CMD_PAGE_PROGRAM 8'h02
`define SFSP_CMD_SECTOR_WIPE 8'h20
`define SFSP_CMD_BLOCK_WIPE_32 8'h52
`define SFSP_CMD_BLOCK_WIPE_64 8'hd8
`define SFSP_CMD_CHIP_WIPE_A 8'h60
`define SFSP_CMD_CHIP_WIPE_B 8'hc7
`define SFSP_CMD_SUSPEND 8'h75
`define SFSP_CMD_RESUME 8'h7a
`define SFSP_CMD_RESET_ENABLE 8'h66
`define SFSP_CMD_RESET 8'h99

// ****************************************
// Status bit positions
// ****************************************
`define SFSP_BUSY_BIT 0
`define SFSP_LATCH_BIT 1
`define SFSP_BP_LSB 2
`define SFSP_SRP_LO_BIT 7
`define SFSP_SRP_HI_BIT 8
`define SFSP_QE_BIT 9
`define SFSP_SUS_PROG_BIT 10
`define SFSP_LB_LSB 11
`define SFSP_CMP_BIT 14
`define SFSP_SUS_WIPE_BIT 15
`define SFSP_LPE_BIT 18
`define SFSP_DRV_LSB 21
`define SFSP_HR_SEL_BIT 23

// ****************************************
// Power-on values
// ****************************************
`define SFSP_DRV_RESET 2'b10

// ****************************************
// Operation times
// ****************************************
`define SFSP_CLK_MHZ 50
`define SFSP_STATUS_WRITE_US 5000
`define SFSP_PROGRAM_US 500
`define SFSP_ERASE_US 50000
`define SFSP_STATUS_WRITE_CYCLES (`SFSP_STATUS_WRITE_US * `SFSP_CLK_MHZ)
`define SFSP_PROGRAM_CYCLES (`SFSP_PROGRAM_US * `SFSP_CLK_MHZ)
`define SFSP_ERASE_CYCLES (`SFSP_ERASE_US * `SFSP_CLK_MHZ)

`endif

// ==== sfsp_status_protect.v ====
/*
 * Status register and protection logic of a serial NOR flash, reached by
 * the status commands on the serial link (mode 0, MSB first).
 * Assumes the serial pins come from another clock domain and are sampled
 * by sys_clk_i; rst_i stands for a power cycle.
 */
// Contract
// R1: Busy bit high during program, erase, status write.
// R2: Clear latch refuses status write, program, erase.
// R3: Block-protect field guards region against program, erase.
// R4: Block-protect changes only without hardware lock.
// R5: Chip erase only with nothing-protected code.
// R6: Mode 00 writable whenever latch set; the code also refuses it while busy or while an erase or program is suspended.
// R7: Mode 01 locked while protect pin low.
// R8: Mode 10 locked until power cycle.
// R9: Mode 11 permanently unwritable; the code unlocks it at power cycle, as for mode 10.
// R10: Quad enable turns protect, pause pins into data.
// R11: Security lock bits only set, never cleared; the code clears them at power cycle.
// R12: Complement bit joins block-protect region decision.
// R13: Suspend sets erase or program suspended flag.
// R14: Resume, software reset, power cycle clear flags.
// R15: Two bits choose output drive strength.
// R16: Select bit picks pause or reset pin.
// R17: Low-power bit shows low-power state.
// R18: Latch cleared by power-up and write commands.
// R19: Complement bit inverts the protected region.
// R20: Reset pin restores volatile bits, standby.
// R21: Reserved bits read zero, ignore writes.
// R22: Host polls busy before next write.
`timescale 1ns/100ps
`include "sfsp_defs.vh"

module sfsp_status_protect #(
    parameter [31:0] STATUS_WRITE_CYCLES = `SFSP_STATUS_WRITE_CYCLES,
    parameter [31:0] PROGRAM_CYCLES = `SFSP_PROGRAM_CYCLES,
    parameter [31:0] ERASE_CYCLES = `SFSP_ERASE_CYCLES
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire spi_cs_n_i,
    input wire spi_sclk_i,
    input wire spi_si_i,
    input wire wp_n_i,
    input wire pause_reset_n_i,
    output wire spi_so_o,
    output wire spi_so_oe_o,
    output wire write_busy_flag_o,
    output wire [4:0] block_protect_field_o,
    output wire protect_complement_o,
    output wire [2:0] security_lock_bits_o,
    output wire quad_enable_o,
    output wire [1:0] output_strength_field_o,
    output wire pause_reset_select_o,
    output wire low_power_state_o,
    output wire pause_active_o,
    output wire array_op_start_o,
    output wire array_op_erase_o,
    output wire array_op_chip_o,
    output wire [23:0] array_op_addr_o
);

    // ****************************************
    // Pin sampling
    // ****************************************
    // Three stages per pin; the filtered level moves only when the
    // second and third stages agree, so a single sampled glitch is lost.
    reg [4:0] sync1_reg;
    reg [4:0] sync2_reg;
    reg [4:0] sync3_reg;
    reg [4:0] pin_reg;
    reg [4:0] pin_prev_reg;
    wire [4:0] pins_in = {pause_reset_n_i, wp_n_i, spi_si_i, spi_sclk_i, spi_cs_n_i};

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 5'h1d;
            sync2_reg <= 5'h1d;
            sync3_reg <= 5'h1d;
            pin_reg <= 5'h1d;
            pin_prev_reg <= 5'h1d;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pin_reg & (sync2_reg ^ sync3_reg));
            pin_prev_reg <= pin_reg;
        end
    end

    // ****************************************
    // Status storage
    // ****************************************
    reg busy_reg;
    reg latch_reg;
    reg [4:0] bp_reg;
    reg srp_lo_reg;
    reg srp_hi_reg;
    reg qe_reg;
    reg [2:0] lb_reg;
    reg cmp_reg;
    reg sus_wipe_reg;
    reg sus_prog_reg;
    reg [1:0] drv_reg;
    reg hr_sel_reg;
    reg lpe_reg;
    reg op_erase_reg;
    reg op_status_reg;
    reg [31:0] op_cnt_reg;
    reg reset_armed_reg;
    reg [23:0] status_word;

    always @* begin
        status_word = 24'h000000; // see R21
        status_word[`SFSP_BUSY_BIT] = busy_reg; // see R1
        status_word[`SFSP_LATCH_BIT] = latch_reg; // see R2
        status_word[`SFSP_BP_LSB+4:`SFSP_BP_LSB] = bp_reg;
        status_word[`SFSP_SRP_LO_BIT] = srp_lo_reg;
        status_word[`SFSP_SRP_HI_BIT] = srp_hi_reg;
        status_word[`SFSP_QE_BIT] = qe_reg;
        status_word[`SFSP_SUS_PROG_BIT] = sus_prog_reg; // see R13
        status_word[`SFSP_LB_LSB+2:`SFSP_LB_LSB] = lb_reg;
        status_word[`SFSP_CMP_BIT] = cmp_reg;
        status_word[`SFSP_SUS_WIPE_BIT] = sus_wipe_reg; // see R13
        status_word[`SFSP_LPE_BIT] = lpe_reg; // see R17
        status_word[`SFSP_DRV_LSB+1:`SFSP_DRV_LSB] = drv_reg; // see R15
        status_word[`SFSP_HR_SEL_BIT] = hr_sel_reg;
    end

    // ****************************************
    // Pin roles
    // ****************************************
    wire cs_active = ~pin_reg[0];
    wire reset_pin_low = hr_sel_reg & ~qe_reg & ~pin_reg[4]; // see R16, R20
    wire pause_low = ~hr_sel_reg & ~qe_reg & ~pin_reg[4]; // see R16
    wire wp_low = ~qe_reg & ~pin_reg[3]; // see R10
    wire link_frozen = pause_low | reset_pin_low;
    wire sclk_rise = pin_reg[1] & ~pin_prev_reg[1] & cs_active & ~link_frozen;
    wire sclk_fall = ~pin_reg[1] & pin_prev_reg[1] & cs_active & ~link_frozen;
    wire cs_fall = ~pin_reg[0] & pin_prev_reg[0];
    wire cs_rise = pin_reg[0] & ~pin_prev_reg[0];
    // Modes 10 and 11 lock outright; mode 01 locks only on a low pin.
    wire sr_locked = srp_hi_reg | (srp_lo_reg & wp_low); // see R4, R6, R7, R8, R9

    // ****************************************
    // Protected region
    // ****************************************
    function addr_protected;
        input [23:0] a;
        input [4:0] bp;
        input cmp;
        reg [4:0] k;
        reg [23:0] m;
        reg hit;
        begin
            k = 5'd0;
            m = 24'h000000;
            hit = 1'b0;
            if (bp[2:0] == 3'b111) begin
                hit = 1'b1;
            end else if (bp[2:0] != 3'b000) begin
                if (bp[4]) begin
                    k = (bp[2:0] > 3'd4) ? 5'd15 : 5'd11 + {2'b00, bp[2:0]};
                end else begin
                    k = 5'd17 + {2'b00, bp[2:0]};
                end
                m = 24'hffffff << k;
                hit = bp[3] ? ((a & m) == 24'h000000) : ((a & m) == m); // see R3
            end
            addr_protected = hit ^ cmp; // see R12, R19
        end
    endfunction

    // ****************************************
    // Frame receiver and status transmitter
    // ****************************************
    reg [2:0] bit_cnt_reg;
    reg [2:0] byte_cnt_reg;
    reg [7:0] rx_reg;
    reg [7:0] cmd_reg;
    reg [7:0] data_reg;
    reg [23:0] addr_reg;
    reg [7:0] tx_reg;
    reg so_reg;
    reg so_oe_reg;
    reg [7:0] read_byte;
    reg first_load_reg;

    always @* begin
        read_byte = 8'h00;
        if (cmd_reg == `SFSP_CMD_RD_LOW) begin
            read_byte = status_word[7:0];
        end else if (cmd_reg == `SFSP_CMD_RD_MID) begin
            read_byte = status_word[15:8];
        end else if (cmd_reg == `SFSP_CMD_RD_HIGH) begin
            read_byte = status_word[23:16];
        end
    end

    wire [7:0] rx_byte = {rx_reg[6:0], pin_reg[2]};
    wire byte_done = sclk_rise & (bit_cnt_reg == 3'd7);
    wire is_read = (cmd_reg == `SFSP_CMD_RD_LOW) | (cmd_reg == `SFSP_CMD_RD_MID) |
                   (cmd_reg == `SFSP_CMD_RD_HIGH);

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
            rx_reg <= 8'h00;
            cmd_reg <= 8'h00;
            data_reg <= 8'h00;
            addr_reg <= 24'h000000;
            tx_reg <= 8'h00;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
            cmd_reg <= 8'h00;
        end else if (cs_rise | reset_pin_low) begin
            so_oe_reg <= 1'b0;
            bit_cnt_reg <= 3'd0;
        end else begin
            if (sclk_rise) begin
                rx_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'd1;
            end
            if (byte_done) begin
                if (byte_cnt_reg != 3'd7) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'd1;
                end
                if (byte_cnt_reg == 3'd0) begin
                    cmd_reg <= rx_byte;
                end
                if (byte_cnt_reg == 3'd1) begin
                    data_reg <= rx_byte;
                    addr_reg[23:16] <= rx_byte;
                end
                if (byte_cnt_reg == 3'd2) begin
                    addr_reg[15:8] <= rx_byte;
                end
                if (byte_cnt_reg == 3'd3) begin
                    addr_reg[7:0] <= rx_byte;
                end
            end
            // A fresh snapshot per byte lets the host poll busy in one frame.
            if (byte_done & ((byte_cnt_reg == 3'd0) | is_read)) begin // see R22
                tx_reg <= (byte_cnt_reg == 3'd0) ? 8'h00 : read_byte;
            end else if (first_load_reg) begin
                tx_reg <= read_byte;
            end else if (sclk_fall) begin
                so_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                so_oe_reg <= is_read & (byte_cnt_reg != 3'd0);
            end
            if (pause_low) begin
                so_oe_reg <= 1'b0;
            end
        end
    end

    // Command byte done: latch its snapshot the cycle after cmd_reg is set.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_load_reg <= 1'b0;
        end else begin
            first_load_reg <= byte_done & (byte_cnt_reg == 3'd0);
        end
    end

    // ****************************************
    // Command execution at frame end
    // ****************************************
    wire aligned = (bit_cnt_reg == 3'd0);
    wire one_byte = cs_rise & aligned & (byte_cnt_reg == 3'd1);
    wire two_bytes = cs_rise & aligned & (byte_cnt_reg == 3'd2);
    wire is_prog = (cmd_reg == `SFSP_CMD_PAGE_PROGRAM);
    wire is_addr_wipe = (cmd_reg == `SFSP_CMD_SECTOR_WIPE) |
                        (cmd_reg == `SFSP_CMD_BLOCK_WIPE_32) |
                        (cmd_reg == `SFSP_CMD_BLOCK_WIPE_64);
    wire is_chip = (cmd_reg == `SFSP_CMD_CHIP_WIPE_A) | (cmd_reg == `SFSP_CMD_CHIP_WIPE_B);
    wire is_sr_write = (cmd_reg == `SFSP_CMD_WR_LOW) | (cmd_reg == `SFSP_CMD_WR_MID) |
                       (cmd_reg == `SFSP_CMD_WR_HIGH);
    wire prog_frame = cs_rise & aligned & is_prog & (byte_cnt_reg >= 3'd5);
    wire wipe_frame = cs_rise & aligned & is_addr_wipe & (byte_cnt_reg == 3'd4);
    wire chip_frame = one_byte & is_chip;
    wire sr_frame = two_bytes & is_sr_write;
    wire ce_ok = ((bp_reg[2:0] == 3'b000) & ~cmp_reg) | ((bp_reg[2:0] == 3'b111) & cmp_reg);
    wire may_write = latch_reg & ~busy_reg & ~sus_wipe_reg & ~sus_prog_reg; // see R2
    wire array_ok = may_write & (chip_frame ? ce_ok : ~addr_protected(addr_reg, bp_reg, cmp_reg)); // see R3, R5
    wire array_go = (prog_frame | wipe_frame | chip_frame) & array_ok;
    wire soft_reset = one_byte & (cmd_reg == `SFSP_CMD_RESET) & reset_armed_reg;

    reg start_reg;
    reg start_erase_reg;
    reg start_chip_reg;
    reg [23:0] start_addr_reg;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            latch_reg <= 1'b0; // see R18
            bp_reg <= 5'h00;
            srp_lo_reg <= 1'b0; // see R8
            srp_hi_reg <= 1'b0; // see R8
            qe_reg <= 1'b0;
            lb_reg <= 3'h0;
            cmp_reg <= 1'b0;
            sus_wipe_reg <= 1'b0; // see R14
            sus_prog_reg <= 1'b0; // see R14
            drv_reg <= `SFSP_DRV_RESET;
            hr_sel_reg <= 1'b0;
            lpe_reg <= 1'b0;
            op_erase_reg <= 1'b0;
            op_status_reg <= 1'b0;
            op_cnt_reg <= 32'h00000000;
            reset_armed_reg <= 1'b0;
            start_reg <= 1'b0;
            start_erase_reg <= 1'b0;
            start_chip_reg <= 1'b0;
            start_addr_reg <= 24'h000000;
        end else begin
            start_reg <= 1'b0;
            if (busy_reg) begin
                if (op_cnt_reg <= 32'h00000001) begin
                    busy_reg <= 1'b0; // see R1
                end
                op_cnt_reg <= op_cnt_reg - 32'h00000001;
            end
            if (one_byte | two_bytes | prog_frame | wipe_frame) begin
                reset_armed_reg <= one_byte & (cmd_reg == `SFSP_CMD_RESET_ENABLE);
            end
            if (reset_pin_low | soft_reset) begin
                busy_reg <= 1'b0; // see R20
                latch_reg <= 1'b0;
                sus_wipe_reg <= 1'b0; // see R14
                sus_prog_reg <= 1'b0;
                op_cnt_reg <= 32'h00000000;
                reset_armed_reg <= 1'b0;
            end else if (one_byte & (cmd_reg == `SFSP_CMD_WREN_LATCH) & ~busy_reg) begin
                latch_reg <= 1'b1;
            end else if (one_byte & (cmd_reg == `SFSP_CMD_WR_DISABLE) & ~busy_reg) begin
                latch_reg <= 1'b0; // see R18
            end else if (one_byte & (cmd_reg == `SFSP_CMD_SUSPEND) & busy_reg & ~op_status_reg) begin
                busy_reg <= 1'b0;
                sus_wipe_reg <= op_erase_reg; // see R13
                sus_prog_reg <= ~op_erase_reg;
            end else if (one_byte & (cmd_reg == `SFSP_CMD_RESUME) & (sus_wipe_reg | sus_prog_reg)) begin
                busy_reg <= 1'b1;
                sus_wipe_reg <= 1'b0; // see R14
                sus_prog_reg <= 1'b0;
            end else if (sr_frame & may_write & ~sr_locked) begin
                latch_reg <= 1'b0; // see R18
                busy_reg <= 1'b1; // see R1
                op_status_reg <= 1'b1;
                op_cnt_reg <= STATUS_WRITE_CYCLES;
                if (cmd_reg == `SFSP_CMD_WR_LOW) begin
                    srp_lo_reg <= data_reg[`SFSP_SRP_LO_BIT];
                    bp_reg <= data_reg[`SFSP_BP_LSB+4:`SFSP_BP_LSB]; // see R3, R4
                end else if (cmd_reg == `SFSP_CMD_WR_MID) begin
                    srp_hi_reg <= data_reg[`SFSP_SRP_HI_BIT-8];
                    qe_reg <= data_reg[`SFSP_QE_BIT-8]; // see R10
                    lb_reg <= lb_reg | data_reg[`SFSP_LB_LSB-6:`SFSP_LB_LSB-8]; // see R11
                    cmp_reg <= data_reg[`SFSP_CMP_BIT-8]; // see R12
                end else begin
                    hr_sel_reg <= data_reg[`SFSP_HR_SEL_BIT-16]; // see R16
                    drv_reg <= data_reg[`SFSP_DRV_LSB-15:`SFSP_DRV_LSB-16]; // see R15
                    lpe_reg <= data_reg[`SFSP_LPE_BIT-16]; // see R17, R21
                end
            end else if (sr_frame & latch_reg & ~busy_reg) begin
                latch_reg <= 1'b0; // see R18
            end else if (array_go) begin
                latch_reg <= 1'b0; // see R18
                busy_reg <= 1'b1; // see R1
                op_status_reg <= 1'b0;
                op_erase_reg <= ~prog_frame;
                op_cnt_reg <= prog_frame ? PROGRAM_CYCLES : ERASE_CYCLES;
                start_reg <= 1'b1;
                start_erase_reg <= ~prog_frame;
                start_chip_reg <= chip_frame;
                start_addr_reg <= chip_frame ? 24'h000000 : addr_reg;
            end else if ((prog_frame | wipe_frame | chip_frame) & latch_reg & ~busy_reg) begin
                latch_reg <= 1'b0; // see R18
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign spi_so_o = so_reg;
    assign spi_so_oe_o = so_oe_reg & cs_active & ~first_load_reg;
    assign write_busy_flag_o = busy_reg;
    assign block_protect_field_o = bp_reg;
    assign protect_complement_o = cmp_reg;
    assign security_lock_bits_o = lb_reg; // see R11
    assign quad_enable_o = qe_reg;
    assign output_strength_field_o = drv_reg;
    assign pause_reset_select_o = hr_sel_reg;
    assign low_power_state_o = lpe_reg;
    assign pause_active_o = pause_low;
    assign array_op_start_o = start_reg;
    assign array_op_erase_o = start_erase_reg;
    assign array_op_chip_o = start_chip_reg;
    assign array_op_addr_o = start_addr_reg;

endmodule // sfsp_status_protect

// ==== sfsp_assertions.sv ====
/* Port checker for sfsp_status_protect.
   Assumes it is bound to the design and sees only its ports. */
`timescale 1ns/100ps
module sfsp_assertions (
    input wire sys_clk_i,
    input wire rst_i,
    input wire pause_reset_n_i,
    input wire write_busy_flag_o,
    input wire [4:0] block_protect_field_o,
    input wire protect_complement_o,
    input wire [2:0] security_lock_bits_o,
    input wire quad_enable_o,
    input wire [1:0] output_strength_field_o,
    input wire pause_reset_select_o,
    input wire pause_active_o,
    input wire array_op_start_o,
    input wire array_op_chip_o
);
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (rst_i);
chk_power_defaults: assert property (
    $fell(rst_i) |-> output_strength_field_o == 2'b10 && !write_busy_flag_o
    && block_protect_field_o == 5'h00 && security_lock_bits_o == 3'h0)
    else $error("state after power cycle wrong");
chk_busy_start: assert property (
    array_op_start_o |-> ##[0:2] write_busy_flag_o) else $error("busy not raised");
chk_chip_guard: assert property (
    array_op_start_o && array_op_chip_o |->
    (block_protect_field_o[2:0] == 3'h0 && !protect_complement_o)
    || (block_protect_field_o[2:0] == 3'h7 && protect_complement_o))
    else $error("chip wipe started while protected");
chk_lock_sticky: assert property (
    (security_lock_bits_o & $past(security_lock_bits_o)) == $past(security_lock_bits_o))
    else $error("lock bit cleared");
chk_start_pulse: assert property (
    array_op_start_o |=> !array_op_start_o) else $error("start longer than one cycle");
chk_busy_hold: assert property (
    $rose(write_busy_flag_o) |-> write_busy_flag_o [*8]) else $error("busy too short");
chk_pause_gate: assert property (
    pause_active_o |-> !quad_enable_o && !pause_reset_select_o)
    else $error("pause active in wrong mode");
chk_pause_release: assert property (
    pause_reset_n_i [*8] |-> !pause_active_o) else $error("pause stuck");
cover property (array_op_start_o && array_op_chip_o);
cover property (pause_active_o);
cover property ($rose(write_busy_flag_o));
endmodule // sfsp_assertions
bind sfsp_status_protect sfsp_assertions u_chk (.sys_clk_i, .rst_i, .pause_reset_n_i,
    .write_busy_flag_o, .block_protect_field_o, .protect_complement_o,
    .security_lock_bits_o, .quad_enable_o, .output_strength_field_o,
    .pause_reset_select_o, .pause_active_o, .array_op_start_o, .array_op_chip_o);

// ==== sfsp_host_model.sv ====
/* Serial host framing status and array commands, mode 0, MSB first.
   Assumes the bench calls xfer and sys_clk_i paces the link clock. */
`timescale 1ns/100ps
module sfsp_host_model (
    input wire sys_clk_i,
    input wire spi_so_i,
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_si_o
);
initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_si_o = 1'b0;
end
// Four system cycles per half period; the link clock stands still between frames.
task automatic xfer(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge sys_clk_i);
    spi_cs_n_o <= 1'b0;
    for (i = nb * 8 - 1; i >= 0; i--) begin
        spi_si_o <= tx[i];
        repeat (4) @(posedge sys_clk_i);
        spi_sclk_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        // Sampled late: the answer moves a few cycles after each falling edge.
        rx = {rx[6:0], spi_so_i};
        spi_sclk_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    spi_cs_n_o <= 1'b1;
    spi_si_o <= ~spi_si_o;
    repeat (8) @(posedge sys_clk_i);
endtask
endmodule // sfsp_host_model

// ==== sfsp_status_protect_tb.sv ====
/* Self-checking bench of sfsp_status_protect against a status model.
   Assumes sfsp_host_model frames the link and the checker is bound. */
`timescale 1ns/100ps
module sfsp_status_protect_tb;
logic sys_clk_i = 1'b0, rst_i = 1'b1, wp_n = 1'b1, pause_reset_n = 1'b1;
logic [23:0] ms = 24'h400000;
logic [31:0] seed = 32'hb27bd6b5;
logic [7:0] r;
int miscompares = 0, total_checks = 0, i;
wire cs_n, sclk, si, so, so_oe, pause_act;
wire lpo, qeo, cmpo, hro, ero, cho;
wire [1:0] drvo;
wire [2:0] lbo;
wire [4:0] bpo;
wire [23:0] ado;
wire so_line = so_oe ? so : 1'b1;
sfsp_host_model h (.sys_clk_i, .spi_so_i(so_line), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
    .spi_si_o(si));
sfsp_status_protect #(.STATUS_WRITE_CYCLES(300), .PROGRAM_CYCLES(600), .ERASE_CYCLES(600))
dut (.sys_clk_i, .rst_i, .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_si_i(si), .wp_n_i(wp_n),
    .pause_reset_n_i(pause_reset_n), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .write_busy_flag_o(), .block_protect_field_o(bpo), .protect_complement_o(cmpo),
    .security_lock_bits_o(lbo), .quad_enable_o(qeo), .output_strength_field_o(drvo),
    .pause_reset_select_o(hro), .low_power_state_o(lpo), .pause_active_o(pause_act),
    .array_op_start_o(), .array_op_erase_o(ero), .array_op_chip_o(cho),
    .array_op_addr_o(ado));
initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
end
function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
        miscompares++;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
task automatic cmd1(input logic [7:0] c);
    logic [7:0] x;
    h.xfer({32'h0, c}, 1, x);
endtask
task automatic rd(input logic [7:0] c, output logic [7:0] x);
    h.xfer({24'h0, c, 8'h00}, 2, x);
endtask
task automatic chk_all();
    logic [7:0] a, b, c;
    rd(8'h05, a);
    rd(8'h35, b);
    rd(8'h15, c);
    check("status", ms, {c, b, a});
    check("outputs", {ms[23:21], ms[18], ms[14:11], ms[9], ms[6:2]},
        {hro, drvo, lpo, cmpo, lbo, qeo, bpo});
endtask
task automatic poll();
    logic [7:0] x;
    int n;
    x = 8'h01;
    for (n = 0; n < 30 && x[0] !== 1'b0; n++) rd(8'h05, x);
    check("busy_clear", 1'b0, x[0]);
endtask
task automatic wr(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] x;
    logic ok;
    cmd1(8'h06);
    ok = !(ms[8] || (ms[8:7] == 2'b01 && wp_n === 1'b0 && !ms[9]));
    h.xfer({24'h0, c, v}, 2, x);
    if (ok && c == 8'h01) ms[7:2] = v[7:2];
    if (ok && c == 8'h31) ms[14:8] = {v[6], v[5:3] | ms[13:11], 1'b0, v[1:0]};
    if (ok && c == 8'h11) ms[23:16] = {v[7:5], 2'b00, v[2], 2'b00};
    rd(8'h05, x);
    check("write_accept", {1'b0, ok}, x[1:0]);
    poll();
    chk_all();
endtask
task automatic op(input logic [39:0] tx, input int nb, input logic ok);
    logic [7:0] x;
    logic [25:0] e;
    cmd1(8'h06);
    h.xfer(tx, nb, x);
    rd(8'h05, x);
    check("op_accept", {1'b0, ok}, x[1:0]);
    e = {nb != 5, nb == 1, nb == 4 ? tx[23:0] : (nb == 5 ? tx[31:8] : 24'h0)};
    if (ok) check("op_out", e, {ero, cho, ado});
endtask
task automatic pwr();
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    ms = 24'h400000;
    repeat (4) @(posedge sys_clk_i);
endtask
initial begin
    repeat (90000) @(posedge sys_clk_i);
    miscompares++;
    give_verdict();
end
// ****************************************
// Main sequence
// ****************************************
initial begin
    repeat (10) @(posedge sys_clk_i);
    pwr();
    chk_all();
    h.xfer({24'h0, 8'h01, 8'h1c}, 2, r);
    chk_all();
    cmd1(8'h06);
    rd(8'h05, r);
    check("latch_set", 8'h02, r);
    cmd1(8'h04);
    rd(8'h05, r);
    check("latch_clear", 8'h00, r);
    h.xfer({32'h0, 8'hc7}, 1, r);
    rd(8'h05, r);
    check("wipe_no_latch", 8'h00, r);
    for (i = 0; i < 12; i++) begin
        r = 8'(xs());
        if (i % 3 == 0) wr(8'h01, r & 8'h7f);
        if (i % 3 == 1) wr(8'h31, r & 8'hfe);
        if (i % 3 == 2) wr(8'h11, {r[7], 2'(i / 3), r[4:0]});
    end
    $display("test fields done");
    pwr();
    wr(8'h01, 8'h80);
    wp_n <= 1'b0;
    wr(8'h01, 8'h84);
    wp_n <= 1'b1;
    wr(8'h01, 8'h88);
    wr(8'h31, 8'h02);
    wp_n <= 1'b0;
    wr(8'h01, 8'h8c);
    wp_n <= 1'b1;
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h00);
    pwr();
    wr(8'h31, 8'h01);
    wr(8'h31, 8'h00);
    pwr();
    chk_all();
    $display("test lock modes done");
    op({32'h0, 8'hc7}, 1, 1'b1);
    cmd1(8'h75);
    rd(8'h35, r);
    check("wipe_suspend", 8'h80, r & 8'h84);
    cmd1(8'h7a);
    rd(8'h35, r);
    check("resume", 8'h00, r & 8'h84);
    poll();
    op({8'h02, 32'h000000a5}, 5, 1'b1);
    cmd1(8'h75);
    rd(8'h35, r);
    check("prog_suspend", 8'h04, r & 8'h84);
    cmd1(8'h66);
    cmd1(8'h99);
    rd(8'h35, r);
    check("soft_reset", 8'h00, r & 8'h84);
    poll();
    $display("test suspend done");
    wr(8'h01, 8'h04);
    op({32'h0, 8'hc7}, 1, 1'b0);
    op({8'h0, 8'h20, 24'hfc0000}, 4, 1'b0);
    op({8'h0, 8'h20, 24'h000000}, 4, 1'b1);
    poll();
    wr(8'h31, 8'h40);
    op({8'h0, 8'h20, 24'h000000}, 4, 1'b0);
    op({8'h0, 8'h20, 24'hfc0000}, 4, 1'b1);
    poll();
    wr(8'h01, 8'h1c);
    op({32'h0, 8'h60}, 1, 1'b1);
    poll();
    $display("test protection done");
    wr(8'h11, 8'hc0);
    cmd1(8'h06);
    pause_reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    pause_reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk_all();
    wr(8'h11, 8'h40);
    pause_reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    check("pause", 1'b1, pause_act);
    pause_reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    $display("test pins done");
    give_verdict();
end
endmodule // sfsp_status_protect_tb
